// ### src/icadl_pkg.sv
// Package for the I/O channel address and word hold block and its processor end.
// Assumes a single 200 MHz clock shared by both ends and by the APB master.
package icadl_pkg;
    // Widths of the channel paths
    localparam int HOLD_W       = 16;
    localparam int PORT_N       = 8;

    // Clock and strobe timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int ADR_LOW_NS     = 20;
    localparam int WORD_LOW_NS    = 20;
    localparam int SETUP_NS       = 5;
    localparam int ADR_LOW_CYC    = (ADR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WORD_LOW_CYC   = (WORD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Hold register reset values (word held as idle line level)
    localparam logic [HOLD_W:1] WORD_HOLD_RST    = 16'hffff;
    localparam logic [HOLD_W:1] ADDRESS_HOLD_RST = 16'h0000;

    // Address field positions, numbered with bit 16 as most significant
    localparam int DIRECTOR_BIT = 1;
    localparam int UPPER_LO     = 12;
    localparam int UPPER_HI     = 16;
    localparam int SCHEME_BIT   = 11;
    localparam int EQUIP_LO     = 8;
    localparam int EQUIP_HI     = 10;

    // Processor end APB register offsets
    localparam logic [7:0] ADDR_REG_OFS   = 8'h00;
    localparam logic [7:0] WORD_REG_OFS   = 8'h04;
    localparam logic [7:0] CTRL_REG_OFS   = 8'h08;
    localparam logic [7:0] STATUS_REG_OFS = 8'h0c;
    localparam logic [7:0] ECHO_REG_OFS   = 8'h10;

    // Control and status field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_AUTO  = 2;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_ZERO  = 2;
    localparam int STAT_DIR   = 3;
    localparam int STAT_PORT  = 8;

    // Processor end sequencer states, Gray coded from idle to word low; the step from word low back to idle flips two bits
    typedef enum logic [2:0] {
        ICADL_IDLE     = 3'b000,
        ICADL_ADR_LOW  = 3'b001,
        ICADL_ADR_HIGH = 3'b011,
        ICADL_WORD_PUT = 3'b010,
        ICADL_WORD_LOW = 3'b110
    } icadl_state_e;
endpackage : icadl_pkg

// ### src/icadl_chan_if.sv
// Interface joining the processor end to the address and word hold end.
// Assumes both ends sit on one clock; all signals are plain levels.
`timescale 1ns/1ps
interface icadl_chan_if;
    // Processor to hold block
    logic [0:15]  cpu_transfer_line_n;
    logic         address_strobe_n;
    logic         word_strobe_n;
    logic         write_ind;
    logic         auto_data;
    // Hold block to channel
    logic [16:1]  channel_address_line_n;
    logic [16:1]  channel_word_line_n;
    logic         director;
    logic         upper_field_zero_n;
    logic [7:0]   port_select_n;
    logic         word_loaded;

    modport cpu (
        output cpu_transfer_line_n, address_strobe_n, word_strobe_n, write_ind, auto_data,
        input  channel_address_line_n, channel_word_line_n, director,
        input  upper_field_zero_n, port_select_n, word_loaded
    );
    modport dev (
        input  cpu_transfer_line_n, address_strobe_n, word_strobe_n, write_ind, auto_data,
        output channel_address_line_n, channel_word_line_n, director,
        output upper_field_zero_n, port_select_n, word_loaded
    );
endinterface : icadl_chan_if

// ### src/icadl_hold.sv
// Address and word hold end: latches the peripheral address and word from the
// processor strobes, drives them onto the channel and decodes the port selects.
// Assumes strobes and transfer lines are synchronous to ref_clk and that the
// transfer lines are stable in the first cycle a strobe is sampled low.
//
// Functional notes
// (R1) Each output captures address and word
// (R2) Bit 16 is most significant, order kept
// (R3) Word from lines, address from inverted word
// (R4) Processor lowers address strobe with address
// (R5) Address strobe fall loads word hold
// (R6) Address strobe rise loads address hold
// (R7) Processor presents word, then lowers word strobe
// (R8) Word strobe fall overwrites word hold
// (R9) Drive 16 address and 16 word lines
// (R10) Address bit 1 marks function versus data
// (R11) Upper field zero raises low flag
// (R12) Decoder needs zero field, write, bit 11
// (R13) One of eight port selects by bits 8-10
// (R14) Controller decodes position bits 5-7 itself
// (R15) Auto data also selects set/sample scheme
// (R16) Auto data enables second group without write
// (R17) Hold registers stable between strobes
`timescale 1ns/1ps
module icadl_hold #(
    parameter int HOLD_W = icadl_pkg::HOLD_W,
    parameter int PORT_N = icadl_pkg::PORT_N
) (
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Processor and channel link
    icadl_chan_if.dev   chan,
    // User side status
    output logic        address_valid,
    output logic        word_valid,
    output logic        scheme_selected
);

    // Hold registers
    logic [HOLD_W:1] word_hold;
    logic [HOLD_W:1] address_hold;

    // Strobe history for edge detection
    logic            adr_strobe_q;
    logic            word_strobe_q;
    logic            adr_fall;
    logic            adr_rise;
    logic            word_fall;

    // Decode terms
    logic            upper_zero;
    logic            scheme_bit;
    logic [2:0]      equip_sel;
    logic            group_lo_en;
    logic            group_hi_en;
    logic [PORT_N-1:0] next_port_select_n;

    // Previous address strobe level; idle high after reset so no false edge appears
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adr_strobe_q <= 1'b1;
        end else begin
            adr_strobe_q <= chan.address_strobe_n;
        end
    end

    // Previous word strobe level, same idle level as the pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_strobe_q <= 1'b1;
        end else begin
            word_strobe_q <= chan.word_strobe_n;
        end
    end

    // Strobe edges
    assign adr_fall  = adr_strobe_q & ~chan.address_strobe_n;
    assign adr_rise  = ~adr_strobe_q & chan.address_strobe_n;
    assign word_fall = word_strobe_q & ~chan.word_strobe_n;

    // Word hold takes the low-active lines as they stand, leftmost bit into bit 16
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_hold <= icadl_pkg::WORD_HOLD_RST;
        end else if (adr_fall) begin
            word_hold <= chan.cpu_transfer_line_n; // R1 R2 R3 R5
        end else if (word_fall) begin
            word_hold <= chan.cpu_transfer_line_n; // R1 R8
        end
    end

    // Address hold loads from the inverted word hold on the trailing strobe edge;
    // by then the word hold still carries the address copy
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            address_hold <= icadl_pkg::ADDRESS_HOLD_RST;
        end else if (adr_rise) begin
            address_hold <= ~word_hold; // R1 R3 R6 R17
        end
    end

    // Phase flags: the word is only meaningful once an address has landed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            address_valid <= 1'b0;
        end else if (adr_fall) begin
            address_valid <= 1'b0;
        end else if (adr_rise) begin
            address_valid <= 1'b1;
        end
    end

    // Word is valid from its strobe until the next address phase begins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_valid <= 1'b0;
        end else if (adr_fall) begin
            word_valid <= 1'b0;
        end else if (word_fall) begin
            word_valid <= address_valid;
        end
    end

    // One-cycle notice to the controllers, one cycle before a fresh word reaches the word lines
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.word_loaded <= 1'b0;
        end else begin
            chan.word_loaded <= word_fall & address_valid;
        end
    end

    // Address lines from the inverted hold outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.channel_address_line_n <= ~icadl_pkg::ADDRESS_HOLD_RST;
        end else begin
            chan.channel_address_line_n <= ~address_hold; // R9 R17
        end
    end

    // Word lines from the true hold outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.channel_word_line_n <= icadl_pkg::WORD_HOLD_RST;
        end else begin
            chan.channel_word_line_n <= word_hold; // R9
        end
    end

    // Director follows address bit 1, in step with the address lines
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.director <= 1'b0;
        end else begin
            chan.director <= address_hold[icadl_pkg::DIRECTOR_BIT]; // R10
        end
    end

    // Address field decode
    assign upper_zero  = ~|address_hold[icadl_pkg::UPPER_HI:icadl_pkg::UPPER_LO]; // R11
    assign scheme_bit  = address_hold[icadl_pkg::SCHEME_BIT];
    assign equip_sel   = address_hold[icadl_pkg::EQUIP_HI:icadl_pkg::EQUIP_LO];

    // Lower group needs the write indication; the upper group also opens on auto data,
    // so block transfers can reach set/sample ports without a write cycle
    assign group_lo_en = upper_zero & scheme_bit & chan.write_ind; // R12 R16
    assign group_hi_en = upper_zero & scheme_bit & (chan.write_ind | chan.auto_data); // R12 R15 R16

    // One-hot low-active port select, bit 10 picking the group of four
    always_comb begin
        next_port_select_n = '1;
        for (int i = 0; i < PORT_N; i++) begin
            if (equip_sel == 3'(i)) begin
                if (i < PORT_N / 2) begin
                    next_port_select_n[i] = ~group_lo_en; // R13
                end else begin
                    next_port_select_n[i] = ~group_hi_en; // R13
                end
            end
        end
    end

    // Zero-field flag, registered so it moves with the address lines
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.upper_field_zero_n <= 1'b1;
        end else begin
            chan.upper_field_zero_n <= ~upper_zero; // R11
        end
    end

    // Port selects; position bits are left to the controllers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.port_select_n <= '1;
        end else begin
            chan.port_select_n <= next_port_select_n; // R13
        end
    end

    // User side copy of any active select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scheme_selected <= 1'b0;
        end else begin
            scheme_selected <= ~&next_port_select_n;
        end
    end

endmodule : icadl_hold

// ### src/icadl_cpu.sv
// Processor end: takes address and word from APB registers and strobes them
// onto the shared transfer lines in two phases.
// Assumes an APB master on ref_clk; the far end answers with no handshake.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module icadl_cpu #(
    parameter int ADR_LOW_CYC  = icadl_pkg::ADR_LOW_CYC,
    parameter int WORD_LOW_CYC = icadl_pkg::WORD_LOW_CYC,
    parameter int SETUP_CYC    = icadl_pkg::SETUP_CYC
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Link to the hold block
    icadl_chan_if.cpu         chan
);

    logic [15:0]        addr_word;
    logic [15:0]        data_word;
    logic               write_mode;
    logic               auto_mode;
    logic               done;
    logic               wr_en;
    logic               start;
    logic               finish;
    logic [7:0]         cnt;
    icadl_pkg::icadl_state_e state;

    // Access strobe; zero wait state
    assign wr_en  = psel & penable & pwrite;
    assign pready = 1'b1;
    assign start  = wr_en && paddr == icadl_pkg::CTRL_REG_OFS && pwdata[icadl_pkg::CTRL_START]
                    && state == icadl_pkg::ICADL_IDLE;

    // Software registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_word  <= 16'h0000;
            data_word  <= 16'h0000;
            write_mode <= 1'b0;
            auto_mode  <= 1'b0;
        end else if (wr_en) begin
            if (paddr == icadl_pkg::ADDR_REG_OFS) begin
                addr_word <= pwdata[15:0];
            end
            if (paddr == icadl_pkg::WORD_REG_OFS) begin
                data_word <= pwdata[15:0];
            end
            if (paddr == icadl_pkg::CTRL_REG_OFS) begin
                write_mode <= pwdata[icadl_pkg::CTRL_WRITE];
                auto_mode  <= pwdata[icadl_pkg::CTRL_AUTO];
            end
        end
    end

    // Done flag; a finishing transfer wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
        end else if (finish) begin
            done <= 1'b1;
        end else if (wr_en && paddr == icadl_pkg::STATUS_REG_OFS
                     && pwdata[icadl_pkg::STAT_DONE]) begin
            done <= 1'b0;
        end
    end

    // Read mux and error on unmapped offsets
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            icadl_pkg::ADDR_REG_OFS: prdata[15:0] = addr_word;
            icadl_pkg::WORD_REG_OFS: prdata[15:0] = data_word;
            icadl_pkg::CTRL_REG_OFS: begin
                prdata[icadl_pkg::CTRL_WRITE] = write_mode;
                prdata[icadl_pkg::CTRL_AUTO]  = auto_mode;
            end
            icadl_pkg::STATUS_REG_OFS: begin
                prdata[icadl_pkg::STAT_BUSY] = state != icadl_pkg::ICADL_IDLE;
                prdata[icadl_pkg::STAT_DONE] = done;
                prdata[icadl_pkg::STAT_ZERO] = chan.upper_field_zero_n;
                prdata[icadl_pkg::STAT_DIR]  = chan.director;
                prdata[icadl_pkg::STAT_PORT +: 8] = chan.port_select_n;
            end
            icadl_pkg::ECHO_REG_OFS:
                prdata = {~chan.channel_word_line_n, ~chan.channel_address_line_n};
            default: pslverr = psel & penable;
        endcase
    end

    assign finish = state == icadl_pkg::ICADL_WORD_LOW && cnt == 8'd0;

    // Strobe sequencer: address low, release, word setup, word low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= icadl_pkg::ICADL_IDLE;
            cnt   <= 8'd0;
        end else begin
            case (state)
                icadl_pkg::ICADL_IDLE: if (start) begin
                    state <= icadl_pkg::ICADL_ADR_LOW;
                    cnt   <= 8'(ADR_LOW_CYC - 1);
                end
                icadl_pkg::ICADL_ADR_LOW: if (cnt == 8'd0) begin
                    state <= icadl_pkg::ICADL_ADR_HIGH;
                    cnt   <= 8'(SETUP_CYC - 1);
                end else begin
                    cnt <= cnt - 8'd1;
                end
                icadl_pkg::ICADL_ADR_HIGH: if (cnt == 8'd0) begin
                    state <= icadl_pkg::ICADL_WORD_PUT;
                    cnt   <= 8'(SETUP_CYC - 1);
                end else begin
                    cnt <= cnt - 8'd1;
                end
                icadl_pkg::ICADL_WORD_PUT: if (cnt == 8'd0) begin
                    state <= icadl_pkg::ICADL_WORD_LOW;
                    cnt   <= 8'(WORD_LOW_CYC - 1);
                end else begin
                    cnt <= cnt - 8'd1;
                end
                icadl_pkg::ICADL_WORD_LOW: if (cnt == 8'd0) begin
                    state <= icadl_pkg::ICADL_IDLE;
                end else begin
                    cnt <= cnt - 8'd1;
                end
                default: state <= icadl_pkg::ICADL_IDLE;
            endcase
        end
    end

    // Link drive; lines carry the inverted value, leftmost line is the top bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan.cpu_transfer_line_n <= 16'hffff;
            chan.address_strobe_n    <= 1'b1;
            chan.word_strobe_n       <= 1'b1;
            chan.write_ind           <= 1'b0;
            chan.auto_data           <= 1'b0;
        end else begin
            chan.write_ind <= write_mode;
            chan.auto_data <= auto_mode;
            if (start) begin
                chan.cpu_transfer_line_n <= ~addr_word; // R4
                chan.address_strobe_n    <= 1'b0; // R4
            end else if (state == icadl_pkg::ICADL_ADR_LOW && cnt == 8'd0) begin
                chan.address_strobe_n <= 1'b1;
            end else if (state == icadl_pkg::ICADL_ADR_HIGH && cnt == 8'd0) begin
                chan.cpu_transfer_line_n <= ~data_word; // R7
            end else if (state == icadl_pkg::ICADL_WORD_PUT && cnt == 8'd0) begin
                chan.word_strobe_n <= 1'b0; // R7
            end else if (finish) begin
                chan.word_strobe_n <= 1'b1;
            end
        end
    end

endmodule : icadl_cpu

// ### dv/icadl_monitor.sv
// Checker on the channel link between the processor end and the hold end.
// Assumes one clock, ref_clk, and rst asynchronous active high.
`timescale 1ns/1ps
module icadl_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Processor side
    input wire logic [0:15] cpu_transfer_line_n,
    input wire logic        address_strobe_n,
    input wire logic        word_strobe_n,
    input wire logic        write_ind,
    input wire logic        auto_data,
    // Channel side
    input wire logic [16:1] channel_address_line_n,
    input wire logic [16:1] channel_word_line_n,
    input wire logic        director,
    input wire logic        upper_field_zero_n,
    input wire logic [7:0]  port_select_n,
    input wire logic        word_loaded
);
    logic [1:0]  live;
    logic [2:0]  as_hist;
    logic [16:1] adr_cap;

    // Port selects expected for a true address
    function automatic logic [7:0] ps_of(input logic [16:1] a, input logic w, input logic au);
        logic [7:0] ps;
        ps = 8'hff;
        if (a[16:12] == 5'h00 && a[11] && (a[10] ? (w || au) : w))
            ps[a[10:8]] = 1'b0;
        return ps;
    endfunction : ps_of

    // Outputs hold reset values one edge past release, so trust them later
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            live    <= 2'h0;
            as_hist <= 3'h7;
            adr_cap <= 16'hffff;
        end else begin
            live    <= (live == 2'h3) ? live : live + 2'h1;
            as_hist <= {as_hist[1:0], address_strobe_n};
            adr_cap <= (as_hist[0] && !address_strobe_n) ? cpu_transfer_line_n : adr_cap;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Strobe falls that start a capture
    sequence s_adr_fall;
        $fell(address_strobe_n);
    endsequence
    sequence s_word_fall;
        $fell(word_strobe_n);
    endsequence

    a_adr_to_word: assert property (
        s_adr_fall |=> ##1 channel_word_line_n == $past(cpu_transfer_line_n, 2))
        else $error("address not caught in word hold");
    a_word_overwrite: assert property (
        s_word_fall |=> ##1 channel_word_line_n == $past(cpu_transfer_line_n, 2))
        else $error("word not caught in word hold");
    a_adr_hold_load: assert property (
        $rose(address_strobe_n) |=> ##1 channel_address_line_n == adr_cap)
        else $error("address hold not loaded");
    a_director_bit: assert property (
        live == 2'h3 |-> director == !channel_address_line_n[1])
        else $error("director differs from address bit 1");
    a_zero_field: assert property (
        live == 2'h3 |-> upper_field_zero_n == (channel_address_line_n[16:12] != 5'h1f))
        else $error("upper field flag wrong");
    a_port_decode: assert property (
        live == 2'h3 |-> port_select_n ==
            ps_of(~channel_address_line_n, $past(write_ind), $past(auto_data)))
        else $error("port select decode wrong");
    a_word_pulse: assert property (
        s_word_fall |-> ##[1:2] word_loaded ##1 !word_loaded)
        else $error("word loaded pulse missing");
    a_adr_steady: assert property (
        live == 2'h3 && as_hist == {3{address_strobe_n}} |-> $stable(channel_address_line_n))
        else $error("address lines moved between strobes");
endmodule : icadl_monitor

// ### dv/icadl_tb.sv
// Testbench: APB drives the processor end, which strobes the hold end.
// Assumes one 200 MHz clock; expectations come from the bench's own model.
`timescale 1ns/1ps
module icadl_tb;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        address_valid, word_valid, scheme_selected, as_prev, ws_prev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, ra, rw;
    logic [15:0] adr_q[$];
    logic [15:0] word_q[$];
    int          bad_count, total_checks, cycles, adr_falls, n0;
    integer      seed;

    icadl_chan_if chan ();
    icadl_cpu icadl_cpu_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan(chan));
    icadl_hold icadl_hold_i (.ref_clk(ref_clk), .rst(rst), .chan(chan),
        .address_valid(address_valid), .word_valid(word_valid),
        .scheme_selected(scheme_selected));
    icadl_monitor icadl_monitor_i (.ref_clk(ref_clk), .rst(rst),
        .cpu_transfer_line_n(chan.cpu_transfer_line_n), .auto_data(chan.auto_data),
        .address_strobe_n(chan.address_strobe_n), .word_strobe_n(chan.word_strobe_n),
        .write_ind(chan.write_ind), .channel_address_line_n(chan.channel_address_line_n),
        .channel_word_line_n(chan.channel_word_line_n), .director(chan.director),
        .upper_field_zero_n(chan.upper_field_zero_n), .port_select_n(chan.port_select_n),
        .word_loaded(chan.word_loaded));

    // Clock, 5 ns period
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // APB master: request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Model of the decoder; the low group never opens on auto data alone
    function automatic logic [7:0] exp_port(input logic [15:0] a, input logic w, input logic au);
        logic [7:0] ps;
        ps = 8'hff;
        if (a[15:11] == 5'h00 && a[10] && (a[9] ? (w || au) : w))
            ps[a[9:7]] = 1'b0;
        return ps;
    endfunction : exp_port

    // One output operation, then every visible result against the model
    task automatic run_op(input logic [15:0] a, input logic [15:0] w, input logic [1:0] q,
                          input logic twice);
        logic [7:0] ps;
        int         n;
        ps = exp_port(a, q[0], q[1]);
        adr_q.push_back(a);
        word_q.push_back(w);
        apb(icadl_pkg::ADDR_REG_OFS, 1'b1, {16'h0, a});
        apb(icadl_pkg::WORD_REG_OFS, 1'b1, {16'h0, w});
        repeat (twice ? 2 : 1) apb(icadl_pkg::CTRL_REG_OFS, 1'b1, {29'h0, q, 1'b1});
        n = 0;
        do begin
            apb(icadl_pkg::STATUS_REG_OFS, 1'b0, 32'h0);
            n++;
        end while (rd[icadl_pkg::STAT_DONE] !== 1'b1 && n < 40);
        check("status", {16'h0, ps, 4'h0, a[0], a[15:11] != 5'h00, 2'h2}, rd & 32'hff0f);
        apb(icadl_pkg::ECHO_REG_OFS, 1'b0, 32'h0);
        check("echo", {w, a}, rd);
        check("ports", {23'h0, ps, a[0]}, {23'h0, chan.port_select_n, chan.director});
        check("flags", {29'h0, 2'h3, ps != 8'hff},
              {29'h0, address_valid, word_valid, scheme_selected});
        apb(icadl_pkg::STATUS_REG_OFS, 1'b1, 32'h2);
    endtask : run_op

    // Wire model: each strobe fall shows the inverted queued value, top line first
    always @(posedge ref_clk) begin
        as_prev <= chan.address_strobe_n;
        ws_prev <= chan.word_strobe_n;
        if (!rst && as_prev && !chan.address_strobe_n) begin
            adr_falls++;
            check("address lines", {16'h0, ~adr_q.pop_front()}, {16'h0, chan.cpu_transfer_line_n});
        end
        if (!rst && ws_prev && !chan.word_strobe_n)
            check("word lines", {16'h0, ~word_q.pop_front()}, {16'h0, chan.cpu_transfer_line_n});
    end

    // Hang guard, far beyond the expected run of about 1300 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        seed = 5740;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        adr_falls = 0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {as_prev, ws_prev} = 2'h3;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("idle", 32'hffffffff, {chan.channel_address_line_n, chan.channel_word_line_n});
        for (int i = 0; i < 32; i++) begin
            ra = $random(seed);
            rw = $random(seed);
            run_op({5'h00, 1'b1, i[2:0], ra[6:0]}, rw[15:0], i[4:3], 1'b0);
        end
        for (int i = 0; i < 12; i++) begin
            ra = $random(seed);
            rw = $random(seed);
            run_op(ra[15:0], rw[15:0], ra[17:16], 1'b0);
        end
        run_op(16'h8580, 16'h0001, 2'h3, 1'b0);
        run_op(16'h0181, 16'hfffe, 2'h1, 1'b0);
        n0 = adr_falls;
        run_op(16'h0700, 16'h1234, 2'h1, 1'b1);
        check("strobe count", 32'h1, adr_falls - n0);
        apb(icadl_pkg::STATUS_REG_OFS, 1'b0, 32'h0);
        check("done cleared", 32'h0, rd & 32'h3);
        apb(8'h14, 1'b0, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], err});
        // Reset in the middle of an address phase
        adr_q.push_back(16'h0700);
        apb(icadl_pkg::CTRL_REG_OFS, 1'b1, 32'h1);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        word_q.delete();
        @(posedge ref_clk);
        check("after reset", 32'hffffff00, {chan.channel_address_line_n, chan.port_select_n,
              5'h0, address_valid, word_valid, scheme_selected});
        run_op(16'h0480, 16'habcd, 2'h1, 1'b0);
        report_and_stop();
    end
endmodule : icadl_tb
